// ---- cmp_regs_pkg.sv ----
// Constants and types shared by the dual comparator register block.
// Overview of operation
// RL1 - Reset clears both control registers and the shared register to zero.
// RL2 - Control register bit 7 enables its comparator when one.
// RL3 - Result bit reads one when plus input exceeds minus, polarity clear.
// RL4 - Pin drive bit routes the result to the output pin, else internal.
// RL5 - Pin is driven only with pin drive, enable set and direction zero.
// RL6 - Invert bit flips the result for both readback and pin.
// RL7 - Speed bit set selects higher speed, clear selects low power.
// RL8 - Plus source bit picks internal reference node or external plus pin.
// RL9 - Two-bit channel code picks one of four shared minus pins.
// RL10 - Shared register bits 7 and 6 mirror both comparator results.
// RL11 - Reading the shared register leaves the mismatch latches alone.
// RL12 - Intref bit set routes variable reference, clear the fixed one.
// RL13 - Shared register bits 3 to 0 ignore writes and read zero.
// RL14 - Port reads return zero for every pin configured analog.
// RL15 - Control register read captures the result into the hold latch.
// RL16 - Any control register write also clears the mismatch.
// RL17 - Interrupt set pulse comes from the mismatch rising edge only.
// RL18 - A disabled comparator reads its invert bit as result.
// RL19 - Raw comparator decisions are synchronised before any use.
// RL20 - Mirror bits always equal the control register result bits.
package cmp_regs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int OFS_W = 5;
    localparam logic [OFS_W-1:0] OFS_CTRL_ONE = 5'h00;
    localparam logic [OFS_W-1:0] OFS_CTRL_TWO = 5'h04;
    localparam logic [OFS_W-1:0] OFS_SHARED = 5'h08;
    localparam logic [OFS_W-1:0] OFS_PORT_VIEW = 5'h0c;
    localparam logic [OFS_W-1:0] OFS_ANALOG_MASK = 5'h10;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int BIT_ENABLE = 7;
    localparam int BIT_RESULT = 6;
    localparam int BIT_PIN_DRIVE = 5;
    localparam int BIT_INVERT = 4;
    localparam int BIT_SPEED = 3;
    localparam int BIT_PLUS_SRC = 2;
    localparam int CHAN_MSB = 1;
    localparam int CHAN_LSB = 0;
    localparam int BIT_MIRROR_ONE = 7;
    localparam int BIT_MIRROR_TWO = 6;
    localparam int BIT_ISEL_ONE = 5;
    localparam int BIT_ISEL_TWO = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SHARED_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hbf;
    localparam logic [7:0] SHARED_WMASK = 8'h30;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RESP = 1'b1
    } bus_state_type;

    typedef enum logic [2:0] {
        SEL_CTRL_ONE,
        SEL_CTRL_TWO,
        SEL_SHARED,
        SEL_PORT,
        SEL_MASK,
        SEL_NONE
    } reg_sel_type;

endpackage

// ---- cmp_chan_if.sv ----
// Signals between the register front end and one comparator channel.
`timescale 1ns/1ps
interface cmp_chan_if;
    logic raw;
    logic enable;
    logic invert;
    logic pin_drive;
    logic dir_bit;
    logic capture;
    logic result;
    logic pin_out;
    logic pin_oe;
    logic irq_set;
    modport ctrl (
        output raw, enable, invert, pin_drive, dir_bit, capture,
        input result, pin_out, pin_oe, irq_set
    );
    modport chan (
        input raw, enable, invert, pin_drive, dir_bit, capture,
        output result, pin_out, pin_oe, irq_set
    );
endinterface

// ---- cmp_channel.sv ----
// One comparator channel: synchroniser, result, mismatch and pin gate.
`timescale 1ns/1ps
module cmp_channel (
    input wire logic aclk,
    input wire logic aresetn,
    cmp_chan_if.chan ch
);
    import cmp_regs_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic result;
        logic hold;
        logic mis;
        logic irq;
    } chan_state_type;

    chan_state_type st_q;
    chan_state_type st_d;
    logic mis_now;

    always_comb begin
        st_d = st_q;
        st_d.s1 = ch.raw; // RL19
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.level = st_q.s3;
        end
        // A disabled comparator shows its invert bit so software can
        // preset the hold latch before switching it on.
        if (ch.enable) begin
            st_d.result = st_q.level ^ ch.invert; // RL3 RL6
        end else begin
            st_d.result = ch.invert; // RL18
        end
        if (ch.capture) begin
            st_d.hold = st_q.result; // RL15 RL16
        end
        mis_now = st_q.hold ^ st_q.result;
        st_d.mis = mis_now;
        st_d.irq = mis_now & ~st_q.mis; // RL17
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ch.result = st_q.result;
    assign ch.pin_out = st_q.result; // RL4 RL6
    assign ch.pin_oe = ch.pin_drive & ch.enable & ~ch.dir_bit; // RL5
    assign ch.irq_set = st_q.irq;

    chk_off_result: assert property ( // RL18
        @(posedge aclk) disable iff (!aresetn)
        !ch.enable ##1 !ch.enable |-> ch.result == $past(ch.invert))
        else $error("disabled result differs from invert bit");
    chk_result_pol: assert property ( // RL3
        @(posedge aclk) disable iff (!aresetn)
        ch.enable |=> ch.result == ($past(st_q.level) ^ $past(ch.invert)))
        else $error("result does not follow level and polarity");
    chk_pin_gate: assert property ( // RL5
        @(posedge aclk) disable iff (!aresetn)
        ch.pin_oe |-> ch.pin_drive && ch.enable && !ch.dir_bit)
        else $error("pin driven without all three conditions");
    chk_irq_edge: assert property ( // RL17
        @(posedge aclk) disable iff (!aresetn)
        ch.irq_set |-> $past(st_q.hold ^ st_q.result, 1) && !$past(st_q.mis))
        else $error("interrupt set without a mismatch edge");
    chk_capture_clear: assert property ( // RL16
        @(posedge aclk) disable iff (!aresetn)
        ch.capture ##1 $stable(st_q.result) |-> st_q.hold == st_q.result)
        else $error("capture did not clear the mismatch");

endmodule

// ---- cmp_regs_top.sv ----
// Dual comparator control registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
module cmp_regs_top #(
    parameter int ADDR_W = 8,
    parameter int PIN_COUNT = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic cmp_one_raw,
    input wire logic cmp_two_raw,
    input wire logic port_dir_one,
    input wire logic port_dir_two,
    input wire logic [PIN_COUNT-1:0] port_pins,
    output logic cmp_one_enable,
    output logic cmp_two_enable,
    output logic cmp_one_speed_sel,
    output logic cmp_two_speed_sel,
    output logic cmp_one_plus_src,
    output logic cmp_two_plus_src,
    output logic [1:0] cmp_one_minus_chan,
    output logic [1:0] cmp_two_minus_chan,
    output logic cmp_one_intref_sel,
    output logic cmp_two_intref_sel,
    output logic cmp_one_pin_out,
    output logic cmp_one_pin_oe,
    output logic cmp_two_pin_out,
    output logic cmp_two_pin_oe,
    output logic [1:0] cmp_irq_set
);
    import cmp_regs_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Only the low data byte carries register bits, so the port view
    // cannot hold more than eight pins.
    generate
        if (ADDR_W < OFS_W || ADDR_W > 32) begin : g_bad_addr
            $error("ADDR_W must lie between 5 and 32");
        end
        if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : g_bad_pins
            $error("PIN_COUNT must lie between 1 and 8");
        end
    endgenerate

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bus_state_type wst;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [7:0] w_data;
        logic w_lane;
        logic [1:0] bresp;
        bus_state_type rst;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [7:0] shared;
        logic [PIN_COUNT-1:0] mask;
        logic [PIN_COUNT-1:0] p1;
        logic [PIN_COUNT-1:0] p2;
        logic [PIN_COUNT-1:0] p3;
        logic [PIN_COUNT-1:0] pins;
    } top_state_type;

    top_state_type st_q;
    top_state_type st_d;

    cmp_chan_if one_if ();
    cmp_chan_if two_if ();

    reg_sel_type wr_sel;
    reg_sel_type rd_sel;
    logic do_write;
    logic rd_fire;
    logic [7:0] rd_val;
    logic [PIN_COUNT-1:0] pin_diff;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic reg_sel_type decode(
        input logic [ADDR_W-1:0] addr
    );
        logic [ADDR_W-1:0] word;
        word = addr & ~ADDR_W'(3);
        if (word == ADDR_W'(OFS_CTRL_ONE)) begin
            return SEL_CTRL_ONE;
        end else if (word == ADDR_W'(OFS_CTRL_TWO)) begin
            return SEL_CTRL_TWO;
        end else if (word == ADDR_W'(OFS_SHARED)) begin
            return SEL_SHARED;
        end else if (word == ADDR_W'(OFS_PORT_VIEW)) begin
            return SEL_PORT;
        end else if (word == ADDR_W'(OFS_ANALOG_MASK)) begin
            return SEL_MASK;
        end
        return SEL_NONE;
    endfunction

    // The result bit is not stored here; it is overlaid on read.
    function automatic logic [7:0] ctrl_view(
        input logic [7:0] ctrl,
        input logic res
    );
        logic [7:0] v;
        v = ctrl & CTRL_WMASK;
        v[BIT_RESULT] = res;
        return v;
    endfunction

    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    assign wr_sel = decode(st_q.aw_addr);
    assign rd_sel = decode(s_axi_araddr);
    assign do_write = st_q.wst == ST_IDLE && st_q.aw_have && st_q.w_have;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_awready = st_q.wst == ST_IDLE && !st_q.aw_have;
    assign s_axi_wready = st_q.wst == ST_IDLE && !st_q.w_have;
    assign s_axi_bvalid = st_q.wst == ST_RESP;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.rst == ST_IDLE;
    assign s_axi_rvalid = st_q.rst == ST_RESP;
    assign s_axi_rdata = {24'h000000, st_q.rdata};
    assign s_axi_rresp = st_q.rresp;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 8'h00;
        case (rd_sel)
            SEL_CTRL_ONE: begin
                rd_val = ctrl_view(st_q.ctrl_one, one_if.result); // RL3
            end
            SEL_CTRL_TWO: begin
                rd_val = ctrl_view(st_q.ctrl_two, two_if.result);
            end
            SEL_SHARED: begin
                rd_val = st_q.shared & SHARED_WMASK; // RL13
                rd_val[BIT_MIRROR_ONE] = one_if.result; // RL10 RL20
                rd_val[BIT_MIRROR_TWO] = two_if.result; // RL10 RL20
            end
            SEL_PORT: begin
                rd_val = 8'(st_q.pins & ~st_q.mask); // RL14
            end
            SEL_MASK: begin
                rd_val = 8'(st_q.mask);
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    assign pin_diff = st_q.p2 ^ st_q.p3;

    always_comb begin
        st_d = st_q;
        // Port pins pass three stages; a level counts once two agree.
        st_d.p1 = port_pins;
        st_d.p2 = st_q.p1;
        st_d.p3 = st_q.p2;
        st_d.pins = (st_q.p3 & ~pin_diff) | (st_q.pins & pin_diff);
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_have = 1'b1;
            st_d.w_data = s_axi_wdata[7:0];
            st_d.w_lane = s_axi_wstrb[0];
        end
        case (st_q.wst)
            ST_IDLE: begin
                if (do_write) begin
                    st_d.wst = ST_RESP;
                    st_d.bresp = RESP_OKAY;
                    if (wr_sel == SEL_NONE) begin
                        st_d.bresp = RESP_SLVERR;
                    end
                    if (st_q.w_lane) begin
                        case (wr_sel)
                            SEL_CTRL_ONE: begin
                                st_d.ctrl_one = st_q.w_data & CTRL_WMASK; // RL2
                            end
                            SEL_CTRL_TWO: begin
                                st_d.ctrl_two = st_q.w_data & CTRL_WMASK; // RL2
                            end
                            SEL_SHARED: begin
                                st_d.shared = st_q.w_data & SHARED_WMASK; // RL13
                            end
                            SEL_MASK: begin
                                st_d.mask = st_q.w_data[PIN_COUNT-1:0];
                            end
                            default: begin
                                st_d.mask = st_q.mask;
                            end
                        endcase
                    end
                end
            end
            ST_RESP: begin
                if (s_axi_bready) begin
                    st_d.wst = ST_IDLE;
                    st_d.aw_have = 1'b0;
                    st_d.w_have = 1'b0;
                end
            end
            default: begin
                st_d.wst = ST_IDLE;
            end
        endcase
        case (st_q.rst)
            ST_IDLE: begin
                if (rd_fire) begin
                    st_d.rst = ST_RESP;
                    st_d.rdata = rd_val;
                    st_d.rresp = RESP_OKAY;
                    if (rd_sel == SEL_NONE) begin
                        st_d.rresp = RESP_SLVERR;
                    end
                end
            end
            ST_RESP: begin
                if (s_axi_rready) begin
                    st_d.rst = ST_IDLE;
                end
            end
            default: begin
                st_d.rst = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0; // RL1
            st_q.ctrl_one <= CTRL_RESET; // RL1
            st_q.ctrl_two <= CTRL_RESET; // RL1
            st_q.shared <= SHARED_RESET; // RL1
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Comparator channels
    // ------------------------------------------------------------
    // A write goes through the same capture as a read, so the hold
    // latch takes the result seen before the new settings apply.
    assign one_if.raw = cmp_one_raw;
    assign one_if.enable = st_q.ctrl_one[BIT_ENABLE]; // RL2
    assign one_if.invert = st_q.ctrl_one[BIT_INVERT]; // RL6
    assign one_if.pin_drive = st_q.ctrl_one[BIT_PIN_DRIVE]; // RL4
    assign one_if.dir_bit = port_dir_one;
    assign one_if.capture = (rd_fire && rd_sel == SEL_CTRL_ONE) // RL15 RL11
        || (do_write && wr_sel == SEL_CTRL_ONE); // RL16
    assign two_if.raw = cmp_two_raw;
    assign two_if.enable = st_q.ctrl_two[BIT_ENABLE]; // RL2
    assign two_if.invert = st_q.ctrl_two[BIT_INVERT]; // RL6
    assign two_if.pin_drive = st_q.ctrl_two[BIT_PIN_DRIVE]; // RL4
    assign two_if.dir_bit = port_dir_two;
    assign two_if.capture = (rd_fire && rd_sel == SEL_CTRL_TWO) // RL15 RL11
        || (do_write && wr_sel == SEL_CTRL_TWO); // RL16

    cmp_channel u_chan_one (
        .aclk(aclk),
        .aresetn(aresetn),
        .ch(one_if.chan)
    );

    cmp_channel u_chan_two (
        .aclk(aclk),
        .aresetn(aresetn),
        .ch(two_if.chan)
    );

    // ------------------------------------------------------------
    // Analog controls and pins
    // ------------------------------------------------------------
    assign cmp_one_enable = st_q.ctrl_one[BIT_ENABLE]; // RL2
    assign cmp_two_enable = st_q.ctrl_two[BIT_ENABLE]; // RL2
    assign cmp_one_speed_sel = st_q.ctrl_one[BIT_SPEED]; // RL7
    assign cmp_two_speed_sel = st_q.ctrl_two[BIT_SPEED]; // RL7
    assign cmp_one_plus_src = st_q.ctrl_one[BIT_PLUS_SRC]; // RL8
    assign cmp_two_plus_src = st_q.ctrl_two[BIT_PLUS_SRC]; // RL8
    assign cmp_one_minus_chan = st_q.ctrl_one[CHAN_MSB:CHAN_LSB]; // RL9
    assign cmp_two_minus_chan = st_q.ctrl_two[CHAN_MSB:CHAN_LSB]; // RL9
    assign cmp_one_intref_sel = st_q.shared[BIT_ISEL_ONE]; // RL12
    assign cmp_two_intref_sel = st_q.shared[BIT_ISEL_TWO]; // RL12
    assign cmp_one_pin_out = one_if.pin_out; // RL4
    assign cmp_one_pin_oe = one_if.pin_oe; // RL5
    assign cmp_two_pin_out = two_if.pin_out; // RL4
    assign cmp_two_pin_oe = two_if.pin_oe; // RL5
    assign cmp_irq_set = {two_if.irq_set, one_if.irq_set}; // RL17

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_reset_zero: assert property ( // RL1
        @(posedge aclk)
        $rose(aresetn) |-> st_q.ctrl_one == CTRL_RESET
            && st_q.ctrl_two == CTRL_RESET && st_q.shared == SHARED_RESET)
        else $error("registers not cleared by reset");
    chk_enable_write: assert property ( // RL2
        @(posedge aclk) disable iff (!aresetn)
        do_write && wr_sel == SEL_CTRL_ONE && st_q.w_lane
        |=> cmp_one_enable == $past(st_q.w_data[BIT_ENABLE]))
        else $error("enable bit not taken from write data");
    chk_mirror_read: assert property ( // RL10
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_sel == SEL_SHARED
        |=> s_axi_rdata[BIT_MIRROR_ONE] == $past(one_if.result)
            && s_axi_rdata[BIT_MIRROR_TWO] == $past(two_if.result))
        else $error("mirror bits differ from results");
    chk_shared_low: assert property ( // RL13
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_sel == SEL_SHARED |=> s_axi_rdata[3:0] == 4'h0)
        else $error("unimplemented shared bits read nonzero");
    chk_mirror_quiet: assert property ( // RL11
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_sel == SEL_SHARED && !do_write
        |-> !one_if.capture && !two_if.capture)
        else $error("shared read disturbed the hold latches");
    chk_ctrl_capture: assert property ( // RL15
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_sel == SEL_CTRL_TWO |-> two_if.capture)
        else $error("control read did not capture");
    chk_write_clear: assert property ( // RL16
        @(posedge aclk) disable iff (!aresetn)
        do_write && wr_sel == SEL_CTRL_ONE |-> one_if.capture)
        else $error("control write did not clear mismatch");
    chk_analog_zero: assert property ( // RL14
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_sel == SEL_PORT
        |=> (s_axi_rdata[PIN_COUNT-1:0] & $past(st_q.mask)) == '0)
        else $error("analog pin read back nonzero");
    chk_intref_sel: assert property ( // RL12
        @(posedge aclk) disable iff (!aresetn)
        do_write && wr_sel == SEL_SHARED && st_q.w_lane
        |=> cmp_two_intref_sel == $past(st_q.w_data[BIT_ISEL_TWO]))
        else $error("reference select not taken from write data");
    chk_pin_oe_two: assert property ( // RL5
        @(posedge aclk) disable iff (!aresetn)
        cmp_two_pin_oe |-> cmp_two_enable && !port_dir_two)
        else $error("pin two driven while gated off");

endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the dual comparator register block.
`timescale 1ns/1ps
module tb_top;
    import cmp_regs_pkg::*;
    localparam logic [7:0] A1 = {3'h0, OFS_CTRL_ONE};
    localparam logic [7:0] A2 = {3'h0, OFS_CTRL_TWO};
    localparam logic [7:0] AS = {3'h0, OFS_SHARED};
    localparam logic [7:0] AP = {3'h0, OFS_PORT_VIEW};
    localparam logic [7:0] AM = {3'h0, OFS_ANALOG_MASK};
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0;
    logic rry = 0, r1 = 0, r2 = 0, pd1 = 0, pd2 = 0;
    logic awr, wr, bv, arr, rv, en1, sp1, ps1, is1, po1, oe1, oe2;
    logic en2, sp2, ps2, is2, po2;
    logic [7:0] awa = 0, ara = 0, pins = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0] br, rr, ch1, ch2, irq;
    logic [33:0] expq[$];
    int failures = 0, samples_checked = 0;

    cmp_regs_top i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .cmp_one_raw(r1), .cmp_two_raw(r2), .port_dir_one(pd1),
        .port_dir_two(pd2), .port_pins(pins), .cmp_one_enable(en1),
        .cmp_two_enable(en2), .cmp_one_speed_sel(sp1),
        .cmp_two_speed_sel(sp2), .cmp_one_plus_src(ps1),
        .cmp_two_plus_src(ps2), .cmp_one_minus_chan(ch1),
        .cmp_two_minus_chan(ch2), .cmp_one_intref_sel(is1),
        .cmp_two_intref_sel(is2), .cmp_one_pin_out(po1),
        .cmp_one_pin_oe(oe1), .cmp_two_pin_out(po2),
        .cmp_two_pin_oe(oe2), .cmp_irq_set(irq)
    );

    // ----------------------------------------
    // Bus tasks and checking
    // ----------------------------------------
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [33:0] ok(input logic [7:0] v);
        return {RESP_OKAY, 24'h0, v};
    endfunction

    // Handshakes are judged at the falling edge, so the ready seen is the
    // one that the next rising edge really samples.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        awa <= a;
        wd <= {24'h0, d};
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && awr;
            tw = pw && wr;
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge aclk); while (!bv);
        @(posedge aclk);
        bry <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        expq.push_back(e);
        do @(negedge aclk); while (!arr);
        @(posedge aclk);
        arv <= 1'b0;
        do @(negedge aclk); while (!rv);
        @(posedge aclk);
        rry <= 1'b0;
    endtask

    // Counting irq[0] high cycles rather than edges catches a pulse held too long; irq[1] is only seen as set or not.
    task automatic pulses(input logic [1:0] e);
        logic [1:0] c;
        logic k;
        c = 2'h0;
        k = 1'b0;
        repeat (12) begin
            @(negedge aclk);
            c = c + irq[0];
            k = k | irq[1];
        end
        @(posedge aclk);
        chk({31'h0, k, c}, {32'h0, e});
    endtask

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(negedge aclk) begin
        if (rv && rry) chk({rr, rd}, expq.pop_front());
    end

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    initial begin
        #100us;
        failures++;
        give_verdict();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [7:0] v, u, s, m, p, g, x;
        logic e1, e2;
        void'($urandom(40));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(A1, ok(8'h00));
        rd_reg(AS, ok(8'h00));
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            v[1:0] = i[1:0];
            u = 8'($urandom);
            s = 8'($urandom);
            m = 8'($urandom);
            p = 8'($urandom);
            r1 <= 1'($urandom);
            r2 <= 1'($urandom);
            pd1 <= 1'($urandom);
            pd2 <= 1'($urandom);
            pins <= p;
            wr_reg(A1, v);
            wr_reg(A2, u);
            wr_reg(AS, s);
            wr_reg(AM, m);
            repeat (8) @(posedge aclk);
            e1 = v[7] ? r1 ^ v[4] : v[4];
            e2 = u[7] ? r2 ^ u[4] : u[4];
            rd_reg(A1, ok({v[7], e1, v[5:0]}));
            rd_reg(A2, ok({u[7], e2, u[5:0]}));
            rd_reg(AS, ok({e1, e2, s[5:4], 4'h0}));
            rd_reg(AP, ok(p & ~m));
            g = {en1, sp1, ps1, ch1, is1, oe1, po1};
            x = {v[7], v[3], v[2], v[1:0], s[5], v[5] & v[7] & ~pd1, e1};
            chk({26'h0, g}, {26'h0, x});
            g = {en2, sp2, ps2, ch2, is2, oe2, po2};
            x = {u[7], u[3], u[2], u[1:0], s[4], u[5] & u[7] & ~pd2, e2};
            chk({26'h0, g}, {26'h0, x});
        end
        rd_reg(8'h14, {RESP_SLVERR, 32'h0});
        $display("test register fields done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        r1 <= 1'b0;
        rd_reg(A1, ok(8'h00));
        wr_reg(A2, 8'h00);
        wr_reg(A1, 8'h80);
        repeat (8) @(posedge aclk);
        rd_reg(A1, ok(8'h80));
        r1 <= 1'b1;
        pulses(2'h1);
        rd_reg(AS, ok(8'h80));
        r1 <= 1'b0;
        pulses(2'h0);
        r1 <= 1'b1;
        pulses(2'h1);
        wr_reg(A1, 8'h80);
        r1 <= 1'b0;
        pulses(2'h1);
        $display("test mismatch events done");
        give_verdict();
    end
endmodule
